// ---- cvbs_pkg.sv ----
// shared constants, register map and carrier types for the composite back end
package cvbs_pkg;

    // register bus geometry, register count, sample, coefficient and line widths
    localparam int          ADDR_W    = 12;
    localparam int          DATA_W    = 32;
    localparam int          SAMPLE_W  = 13;
    localparam int          COEF_W    = 8;
    localparam int          COEF_FRAC = 7;   // s0.7 coefficients
    localparam int          NREG      = 14;
    localparam int          LINE_W    = 10;

    // register indices into the storage array
    localparam int IDX_CSC      = 0;
    localparam int IDX_Y_CLIP   = 1;
    localparam int IDX_U_CLIP   = 2;
    localparam int IDX_V_CLIP   = 3;
    localparam int IDX_YLPF_LO  = 4;
    localparam int IDX_YLPF_HI  = 5;
    localparam int IDX_CLPF_LO  = 6;
    localparam int IDX_CLPF_HI  = 7;
    localparam int IDX_UPF_LO   = 8;
    localparam int IDX_UPF_HI   = 9;
    localparam int IDX_CC_CTL   = 10;
    localparam int IDX_CC_ODD   = 11;
    localparam int IDX_CC_EVEN  = 12;
    localparam int IDX_MODE     = 13;

    // byte offsets, reset values and writable-bit masks, in index order
    localparam logic [ADDR_W-1:0] REG_OFS [NREG] = '{
        12'h0cc, 12'h0f4, 12'h0f8, 12'h0fc, 12'h10c, 12'h110, 12'h114,
        12'h118, 12'h11c, 12'h120, 12'h124, 12'h128, 12'h12c, 12'h0a0};
    localparam logic [DATA_W-1:0] REG_RST [NREG] = '{
        32'h00000000, 32'h00000fff, 32'h180007ff, 32'h180007ff, 32'h00000000,
        32'h00004020, 32'h0c000000, 32'h00002820, 32'h00000000, 32'h004eec06,
        32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000};
    localparam logic [DATA_W-1:0] REG_MASK [NREG] = '{
        32'h00001fff, 32'h1fff1fff, 32'h1fff1fff, 32'h1fff1fff, 32'hffffffff,
        32'h0000ffff, 32'hffffffff, 32'h0000ffff, 32'hffffffff, 32'h00ffffff,
        32'h0000ff03, 32'h0000ffff, 32'h0000ffff, 32'h00000036};

    // read-only caption status register
    localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h140;

    // field positions
    localparam int LO_BOUND_LSB  = 16;
    localparam int HI_BOUND_LSB  = 0;
    localparam int FALLBACK_LSB  = 8;
    localparam int FIELD_SEL_LSB = 0;
    localparam int FIRST_LSB     = 8;
    localparam int SECOND_LSB    = 0;
    localparam int STD_LSB       = 4;
    localparam int CLPF_EN_BIT   = 2;
    localparam int YLPF_EN_BIT   = 1;

    // caption lines per standard
    localparam logic [LINE_W-1:0] LINE_525_ODD  = 10'd21;
    localparam logic [LINE_W-1:0] LINE_525_EVEN = 10'd284;
    localparam logic [LINE_W-1:0] LINE_625_ODD  = 10'd22;
    localparam logic [LINE_W-1:0] LINE_625_EVEN = 10'd335;

    typedef enum logic [1:0] {
        STD_NTSC     = 2'b00,
        STD_PAL      = 2'b01,
        STD_SECAM    = 2'b10,
        STD_RESERVED = 2'b11
    } standard_type;

    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_ODD  = 2'b01,
        SEL_EVEN = 2'b10,
        SEL_BOTH = 2'b11
    } field_sel_type;

    typedef enum logic [0:0] {
        CC_IDLE   = 1'b0,
        CC_SECOND = 1'b1
    } cc_state_type;

    // one component sample set
    typedef struct packed {
        logic signed [SAMPLE_W-1:0] y;
        logic signed [SAMPLE_W-1:0] u;
        logic signed [SAMPLE_W-1:0] v;
    } pix_type;

    // interpolated output pair
    typedef struct packed {
        logic signed [SAMPLE_W-1:0] even;
        logic signed [SAMPLE_W-1:0] odd;
    } up_pair_type;

endpackage

// ---- tap_filter.sv ----
// programmable fir filter with s0.7 coefficients and bypass
`timescale 1ns/1ns
module tap_filter #(
    parameter int TAPS = 6,
    parameter int DW   = 13
) (
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    // sample in
    input  wire logic                    in_valid,
    input  wire logic signed [DW-1:0]    in_sample,
    // control
    input  wire logic [TAPS*8-1:0]       coefs,
    input  wire logic                    enable,
    // sample out
    output logic                         out_valid,
    output logic signed [DW-1:0]         out_sample
);
    localparam int PW = DW + cvbs_pkg::COEF_W;
    localparam int SW = PW + 4;

    if (TAPS < 2 || TAPS > 16) begin : g_bad_taps
        $error("tap_filter: TAPS must be 2..16");
    end

    logic signed [DW-1:0] hist_q [TAPS-1];
    logic signed [DW-1:0] tap    [TAPS];
    logic signed [PW-1:0] prod   [TAPS];
    logic signed [SW-1:0] acc;
    logic signed [SW-1:0] scaled;
    wire  logic signed [DW-1:0] sat_max = {1'b0, {(DW-1){1'b1}}};
    wire  logic signed [DW-1:0] sat_min = {1'b1, {(DW-1){1'b0}}};
    wire  logic signed [DW-1:0] filtered;

    // tap window: newest sample first, then history
    genvar g;
    generate
        for (g = 0; g < TAPS; g++) begin : g_tap
            if (g == 0) begin : g_new
                assign tap[g] = in_sample;
            end else begin : g_old
                assign tap[g] = hist_q[g-1];
            end
            assign prod[g] = tap[g] * $signed(coefs[g*cvbs_pkg::COEF_W +: cvbs_pkg::COEF_W]);
        end
    endgenerate

    // sum of products, wide enough for sixteen taps
    always_comb begin
        acc = '0;
        for (int i = 0; i < TAPS; i++) begin
            acc = acc + SW'(prod[i]);
        end
    end

    // drop fraction bits, then saturate to sample width
    assign scaled   = acc >>> cvbs_pkg::COEF_FRAC;
    assign filtered = (scaled > SW'(sat_max)) ? sat_max :
                      (scaled < SW'(sat_min)) ? sat_min : scaled[DW-1:0];

    // history only moves on valid samples so the kernel spans real pixels
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < TAPS-1; i++) hist_q[i] <= '0;
        end else if (in_valid) begin
            hist_q[0] <= in_sample;
            for (int i = 1; i < TAPS-1; i++) hist_q[i] <= hist_q[i-1];
        end
    end

    // bypass keeps the same one-cycle latency as the filtered path
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_valid  <= 1'b0;
            out_sample <= '0;
        end else begin
            out_valid  <= in_valid;
            out_sample <= enable ? filtered : in_sample;
        end
    end
endmodule

// ---- cvbs_clip_filter_caption.sv ----
// composite back end: register bank, low-pass filters, clipping, upsampler, captions
`timescale 1ns/1ns
module cvbs_clip_filter_caption #(
    parameter int LUMA_TAPS   = 6,
    parameter int CHROMA_TAPS = 6,
    parameter int UP_TAPS     = 7
) (
    // clock and reset
    input  wire logic                                  sys_clk,
    input  wire logic                                  rst,
    // register port
    input  wire logic [cvbs_pkg::ADDR_W-1:0]           reg_addr,
    input  wire logic [cvbs_pkg::DATA_W-1:0]           reg_wdata,
    input  wire logic                                  reg_wr,
    input  wire logic                                  reg_rd,
    output logic      [cvbs_pkg::DATA_W-1:0]           reg_rdata,
    // component samples in
    input  wire cvbs_pkg::pix_type                     pix_in,
    input  wire logic                                  pix_in_valid,
    // component samples out
    output cvbs_pkg::pix_type                          pix_out,
    output logic                                       pix_out_valid,
    // composite samples toward the dacs
    input  wire logic signed [cvbs_pkg::SAMPLE_W-1:0]  cvbs_in,
    input  wire logic                                  cvbs_in_valid,
    output cvbs_pkg::up_pair_type                      up_out,
    output logic                                       up_out_valid,
    // line timing
    input  wire logic                                  line_start,
    input  wire logic [cvbs_pkg::LINE_W-1:0]           line_number,
    input  wire logic                                  field_odd,
    // caption byte stream
    output logic [7:0]                                 caption_byte,
    output logic                                       caption_valid,
    output logic                                       caption_first
);
    localparam int SW = cvbs_pkg::SAMPLE_W;

    // refused at elaboration
    if (LUMA_TAPS != 6 || CHROMA_TAPS != 6 || UP_TAPS != 7) begin : g_bad_taps
        $error("tap counts are fixed by the register layout");
    end

    // ---------------------------------------------------------------
    // register storage
    logic [cvbs_pkg::DATA_W-1:0] reg_q [cvbs_pkg::NREG];
    logic [cvbs_pkg::NREG-1:0]   hit;
    logic                        status_hit;

    // address compare used for both write and read decode
    function automatic logic match(input logic [cvbs_pkg::ADDR_W-1:0] a,
                                   input logic [cvbs_pkg::ADDR_W-1:0] ofs);
        match = (a == ofs);
    endfunction

    genvar r;
    generate
        for (r = 0; r < cvbs_pkg::NREG; r++) begin : g_reg
            assign hit[r] = match(reg_addr, cvbs_pkg::REG_OFS[r]);
            // masked store: reserved bits never hold a one
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    reg_q[r] <= cvbs_pkg::REG_RST[r];
                end else if (reg_wr && hit[r]) begin
                    reg_q[r] <= reg_wdata & cvbs_pkg::REG_MASK[r];
                end
            end
        end
    endgenerate

    assign status_hit = match(reg_addr, cvbs_pkg::STATUS_OFS);

    // ---------------------------------------------------------------
    // field extraction
    logic signed [SW-1:0] csc_offset_coef_third;
    logic signed [SW-1:0] luma_low_bound;
    logic signed [SW-1:0] luma_high_bound;
    logic signed [SW-1:0] u_low_bound;
    logic signed [SW-1:0] u_high_bound;
    logic signed [SW-1:0] v_low_bound;
    logic signed [SW-1:0] v_high_bound;
    logic [LUMA_TAPS*8-1:0]   luma_taps;
    logic [CHROMA_TAPS*8-1:0] chroma_taps;
    logic [UP_TAPS*8-1:0]     interp_taps;
    logic [7:0]               caption_fallback_code;
    cvbs_pkg::field_sel_type  caption_field_select;
    cvbs_pkg::standard_type   composite_modulation_standard;
    logic                     chroma_lpf_en;
    logic                     luma_lpf_en;

    assign csc_offset_coef_third = reg_q[cvbs_pkg::IDX_CSC][SW-1:0];
    assign luma_low_bound  = reg_q[cvbs_pkg::IDX_Y_CLIP][cvbs_pkg::LO_BOUND_LSB +: SW];
    assign luma_high_bound = reg_q[cvbs_pkg::IDX_Y_CLIP][cvbs_pkg::HI_BOUND_LSB +: SW];
    assign u_low_bound     = reg_q[cvbs_pkg::IDX_U_CLIP][cvbs_pkg::LO_BOUND_LSB +: SW];
    assign u_high_bound    = reg_q[cvbs_pkg::IDX_U_CLIP][cvbs_pkg::HI_BOUND_LSB +: SW];
    assign v_low_bound     = reg_q[cvbs_pkg::IDX_V_CLIP][cvbs_pkg::LO_BOUND_LSB +: SW];
    assign v_high_bound    = reg_q[cvbs_pkg::IDX_V_CLIP][cvbs_pkg::HI_BOUND_LSB +: SW];

    // taps 0-3 in the low word, the rest in the low bits of the high word
    assign luma_taps   = {reg_q[cvbs_pkg::IDX_YLPF_HI][15:0], reg_q[cvbs_pkg::IDX_YLPF_LO]};
    assign chroma_taps = {reg_q[cvbs_pkg::IDX_CLPF_HI][15:0], reg_q[cvbs_pkg::IDX_CLPF_LO]};
    assign interp_taps = {reg_q[cvbs_pkg::IDX_UPF_HI][23:0], reg_q[cvbs_pkg::IDX_UPF_LO]};

    assign caption_fallback_code = reg_q[cvbs_pkg::IDX_CC_CTL][cvbs_pkg::FALLBACK_LSB +: 8];
    assign caption_field_select  =
        cvbs_pkg::field_sel_type'(reg_q[cvbs_pkg::IDX_CC_CTL][cvbs_pkg::FIELD_SEL_LSB +: 2]);
    assign composite_modulation_standard =
        cvbs_pkg::standard_type'(reg_q[cvbs_pkg::IDX_MODE][cvbs_pkg::STD_LSB +: 2]);
    assign chroma_lpf_en = reg_q[cvbs_pkg::IDX_MODE][cvbs_pkg::CLPF_EN_BIT];
    assign luma_lpf_en   = reg_q[cvbs_pkg::IDX_MODE][cvbs_pkg::YLPF_EN_BIT];

    // ---------------------------------------------------------------
    // caption freshness and sequencing
    logic fresh_odd_q;
    logic fresh_odd_d;
    logic fresh_even_q;
    logic fresh_even_d;
    cvbs_pkg::cc_state_type cc_state_q;
    cvbs_pkg::cc_state_type cc_state_d;
    logic [7:0] second_q;
    logic [7:0] second_d;
    logic [cvbs_pkg::LINE_W-1:0] odd_line;
    logic [cvbs_pkg::LINE_W-1:0] even_line;
    logic std_valid;
    logic field_on;
    logic slot;
    logic [15:0] pair;
    logic pair_fresh;
    logic wr_odd;
    logic wr_even;

    // 525-line standard uses 21/284, both 625-line standards 22/335
    assign odd_line  = (composite_modulation_standard == cvbs_pkg::STD_NTSC) ?
                       cvbs_pkg::LINE_525_ODD : cvbs_pkg::LINE_625_ODD;
    assign even_line = (composite_modulation_standard == cvbs_pkg::STD_NTSC) ?
                       cvbs_pkg::LINE_525_EVEN : cvbs_pkg::LINE_625_EVEN;
    // reserved standard has no defined caption line, so nothing goes out
    assign std_valid = composite_modulation_standard != cvbs_pkg::STD_RESERVED;

    // field enable by select code
    assign field_on = field_odd ? caption_field_select[0] : caption_field_select[1];
    assign slot     = line_start && std_valid && field_on &&
                      (line_number == (field_odd ? odd_line : even_line));

    // each field carries its own byte pair; stale data falls back
    assign pair_fresh = field_odd ? fresh_odd_q : fresh_even_q;
    assign pair = !pair_fresh ? {caption_fallback_code, caption_fallback_code} :
                  field_odd   ? reg_q[cvbs_pkg::IDX_CC_ODD][15:0] :
                                reg_q[cvbs_pkg::IDX_CC_EVEN][15:0];

    assign wr_odd  = reg_wr && hit[cvbs_pkg::IDX_CC_ODD];
    assign wr_even = reg_wr && hit[cvbs_pkg::IDX_CC_EVEN];

    // a write landing in the slot cycle keeps the mark: set beats clear
    assign fresh_odd_d  = wr_odd  || (fresh_odd_q  && !(slot && field_odd));
    assign fresh_even_d = wr_even || (fresh_even_q && !(slot && !field_odd));

    // two-byte sequence: first byte in the slot cycle's result, second next
    always_comb begin
        cc_state_d = cc_state_q;
        second_d   = second_q;
        case (cc_state_q)
            cvbs_pkg::CC_IDLE: begin
                if (slot) begin
                    cc_state_d = cvbs_pkg::CC_SECOND;
                    second_d   = pair[cvbs_pkg::SECOND_LSB +: 8];
                end
            end
            cvbs_pkg::CC_SECOND: begin
                cc_state_d = cvbs_pkg::CC_IDLE;
            end
            default: begin
                cc_state_d = cvbs_pkg::CC_IDLE;
            end
        endcase
    end

    // caption state registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fresh_odd_q  <= 1'b0;
            fresh_even_q <= 1'b0;
            cc_state_q   <= cvbs_pkg::CC_IDLE;
            second_q     <= 8'h00;
        end else begin
            fresh_odd_q  <= fresh_odd_d;
            fresh_even_q <= fresh_even_d;
            cc_state_q   <= cc_state_d;
            second_q     <= second_d;
        end
    end

    // caption output bytes, first byte high half
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            caption_byte  <= 8'h00;
            caption_valid <= 1'b0;
            caption_first <= 1'b0;
        end else if (cc_state_q == cvbs_pkg::CC_IDLE && slot) begin
            caption_byte  <= pair[cvbs_pkg::FIRST_LSB +: 8];
            caption_valid <= 1'b1;
            caption_first <= 1'b1;
        end else if (cc_state_q == cvbs_pkg::CC_SECOND) begin
            caption_byte  <= second_q;
            caption_valid <= 1'b1;
            caption_first <= 1'b0;
        end else begin
            caption_valid <= 1'b0;
            caption_first <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // register read, one cycle after the strobe; unmapped reads zero
    logic [cvbs_pkg::DATA_W-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        for (int i = 0; i < cvbs_pkg::NREG; i++) begin
            if (hit[i]) rd_mux = reg_q[i];
        end
        if (status_hit) rd_mux = {30'h00000000, fresh_even_q, fresh_odd_q};
    end

    // read data only stand in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

    // ---------------------------------------------------------------
    // luma offset, low-pass filters
    logic signed [SW-1:0] luma_offset;
    logic signed [SW:0]   luma_sum;
    logic signed [SW-1:0] y_filt;
    logic signed [SW-1:0] u_filt;
    logic signed [SW-1:0] v_filt;
    logic                 y_filt_valid;

    // wrap would flip bright to dark, so the offset sum saturates
    assign luma_sum    = {pix_in.y[SW-1], pix_in.y} + {csc_offset_coef_third[SW-1], csc_offset_coef_third};
    assign luma_offset = (luma_sum[SW] != luma_sum[SW-1]) ?
                         {luma_sum[SW], {(SW-1){~luma_sum[SW]}}} : luma_sum[SW-1:0];

    tap_filter #(.TAPS(LUMA_TAPS), .DW(SW)) u_luma_lpf (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .in_valid   (pix_in_valid),
        .in_sample  (luma_offset),
        .coefs      (luma_taps),
        .enable     (luma_lpf_en),
        .out_valid  (y_filt_valid),
        .out_sample (y_filt)
    );

    tap_filter #(.TAPS(CHROMA_TAPS), .DW(SW)) u_u_lpf (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .in_valid   (pix_in_valid),
        .in_sample  (pix_in.u),
        .coefs      (chroma_taps),
        .enable     (chroma_lpf_en),
        .out_valid  (),
        .out_sample (u_filt)
    );

    tap_filter #(.TAPS(CHROMA_TAPS), .DW(SW)) u_v_lpf (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .in_valid   (pix_in_valid),
        .in_sample  (pix_in.v),
        .coefs      (chroma_taps),
        .enable     (chroma_lpf_en),
        .out_valid  (),
        .out_sample (v_filt)
    );

    // ---------------------------------------------------------------
    // signed clamp; lower bound checked last so it wins if limits cross
    function automatic logic signed [SW-1:0] clamp(input logic signed [SW-1:0] s,
                                                   input logic signed [SW-1:0] lo,
                                                   input logic signed [SW-1:0] hi);
        logic signed [SW-1:0] t;
        t = (s > hi) ? hi : s;
        clamp = (t < lo) ? lo : t;
    endfunction

    // clipped components registered for the dacs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pix_out       <= '0;
            pix_out_valid <= 1'b0;
        end else begin
            pix_out.y     <= clamp(y_filt, luma_low_bound, luma_high_bound);
            pix_out.u     <= clamp(u_filt, u_low_bound, u_high_bound);
            pix_out.v     <= clamp(v_filt, v_low_bound, v_high_bound);
            pix_out_valid <= y_filt_valid;
        end
    end

    // ---------------------------------------------------------------
    // 2x interpolation: even phase is the input, odd phase the fir result
    logic signed [SW-1:0] interp;
    logic                 interp_valid;
    logic signed [SW-1:0] cvbs_hold_q;

    tap_filter #(.TAPS(UP_TAPS), .DW(SW)) u_interp (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .in_valid   (cvbs_in_valid),
        .in_sample  (cvbs_in),
        .coefs      (interp_taps),
        .enable     (1'b1),
        .out_valid  (interp_valid),
        .out_sample (interp)
    );

    // hold the even sample to align with the filter latency
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cvbs_hold_q <= '0;
        end else if (cvbs_in_valid) begin
            cvbs_hold_q <= cvbs_in;
        end
    end

    assign up_out.even  = cvbs_hold_q;
    assign up_out.odd   = interp;
    assign up_out_valid = interp_valid;

endmodule

// ---- cvbs_checker.sv ----
// port assertions for the composite back end
`timescale 1ns/1ns
module cvbs_checker (
    // clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rst,
    // register port
    input wire logic                  reg_rd,
    input wire logic [31:0]           reg_rdata,
    // sample paths
    input wire logic                  pix_in_valid,
    input wire logic                  pix_out_valid,
    input wire logic signed [12:0]    cvbs_in,
    input wire logic                  cvbs_in_valid,
    input wire cvbs_pkg::up_pair_type up_out,
    input wire logic                  up_out_valid,
    // captions
    input wire logic                  line_start,
    input wire logic [9:0]            line_number,
    input wire logic                  field_odd,
    input wire logic                  caption_valid,
    input wire logic                  caption_first
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // the two halves of one caption slot
    sequence first_s; caption_valid && caption_first; endsequence
    sequence second_s; caption_valid && !caption_first; endsequence
    rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 0)
        else $error("read data outside its cycle");
    pix_delay_a: assert property (pix_in_valid |-> ##2 pix_out_valid)
        else $error("pixel result late");
    pix_cause_a: assert property (pix_out_valid |-> $past(pix_in_valid, 2))
        else $error("pixel result without input");
    up_even_a: assert property (cvbs_in_valid |=> up_out_valid && up_out.even == $past(cvbs_in))
        else $error("interpolated pair wrong");
    up_cause_a: assert property (up_out_valid |-> $past(cvbs_in_valid))
        else $error("pair without input");
    cap_pair_a: assert property (first_s |=> second_s)
        else $error("second caption byte missing");
    cap_second_a: assert property (second_s |-> $past(caption_first))
        else $error("lone second caption byte");
    cap_line_a: assert property (first_s |-> $past(line_start) && ($past(field_odd) ?
        $past(line_number) inside {10'h015, 10'h016} : $past(line_number) inside {10'h11c, 10'h14f}))
        else $error("caption on wrong line");
endmodule
bind cvbs_clip_filter_caption cvbs_checker cvbs_checker_i (.*);

// ---- cvbs_dac_model.sv ----
// dac side model: takes interpolated pairs and caption bytes
`timescale 1ns/1ns
module cvbs_dac_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // from the encoder
    input wire logic up_out_valid,
    input wire logic caption_valid,
    // tallies
    output int       pair_count,
    output int       byte_count
);
    // dacs never stall, so every valid pulse is one unit taken
    always_ff @(posedge sys_clk) begin
        pair_count <= rst ? 0 : pair_count + int'(up_out_valid);
        byte_count <= rst ? 0 : byte_count + int'(caption_valid);
    end
endmodule

// ---- cvbs_clip_filter_caption_tb.sv ----
// self-checking bench for the composite back end
`timescale 1ns/1ns
module cvbs_clip_filter_caption_tb;
    logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, pix_in_valid = 0, cvbs_in_valid = 0, line_start = 0;
    logic field_odd = 0, caption_valid, caption_first, pix_out_valid, up_out_valid;
    logic [11:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, rd_val;
    logic [9:0] line_number = 0;
    logic [7:0] caption_byte;
    logic signed [12:0] cvbs_in = 0;
    cvbs_pkg::pix_type pix_in = 0, pix_out;
    cvbs_pkg::up_pair_type up_out;
    int bad_count = 0, checks_done = 0, pair_count, byte_count;
    cvbs_clip_filter_caption cvbs_clip_filter_caption_i (.*);
    cvbs_dac_model cvbs_dac_model_i (.*);
    task automatic chk(string what, logic [38:0] seen, logic [38:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // bus cycles: strobes last one cycle, read data taken the cycle after
    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge sys_clk);
        reg_wr <= 0;
    endtask
    task automatic rd(logic [11:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge sys_clk);
        reg_rd <= 0;
        #1 rd_val = reg_rdata;
    endtask
    task automatic px(logic [38:0] d, logic [38:0] e);
        @(posedge sys_clk);
        pix_in <= d;
        pix_in_valid <= 1;
        @(posedge sys_clk);
        pix_in_valid <= 0;
        @(posedge sys_clk);
        #1 chk("pixel", pix_out, e);
    endtask
    // expectations are {valid, first, byte}
    task automatic cap(logic [9:0] n, logic odd, logic [9:0] e1, logic [9:0] e2);
        @(posedge sys_clk);
        line_start <= 1;
        line_number <= n;
        field_odd <= odd;
        @(posedge sys_clk);
        line_start <= 0;
        #1 chk("caption first", {caption_valid, caption_first, caption_valid ? caption_byte : 8'h00}, e1);
        @(posedge sys_clk);
        #1 chk("caption second", {caption_valid, caption_first, caption_valid ? caption_byte : 8'h00}, e2);
    endtask
    task automatic t_regs;
        for (int i = 0; i < cvbs_pkg::NREG; i++) begin
            rd(cvbs_pkg::REG_OFS[i]);
            chk("reset value", rd_val, cvbs_pkg::REG_RST[i] & cvbs_pkg::REG_MASK[i]);
            wr(cvbs_pkg::REG_OFS[i], 32'hffffffff);
            rd(cvbs_pkg::REG_OFS[i]);
            chk("masked write", rd_val, cvbs_pkg::REG_MASK[i]);
            wr(cvbs_pkg::REG_OFS[i], cvbs_pkg::REG_RST[i]);
        end
        rd(12'h130);
        chk("unmapped read", rd_val, 32'h0);
        $display("test registers done");
    endtask
    task automatic t_pix;
        wr(12'h0f4, 32'h00100020);
        px({13'h0100, 13'h1000, 13'h0fff}, {13'h0020, 13'h1800, 13'h07ff});
        px({13'h0005, 13'h0005, 13'h1fff}, {13'h0010, 13'h0005, 13'h1fff});
        wr(12'h0cc, 32'h00000008);
        px({13'h0010, 13'h0000, 13'h0000}, {13'h0018, 13'h0000, 13'h0000});
        wr(12'h10c, 32'h00000040);
        wr(12'h110, 32'h00000000);
        wr(12'h114, 32'h00000040);
        wr(12'h118, 32'h00000000);
        wr(12'h0a0, 32'h00000006);
        px({13'h0038, 13'h0040, 13'h1f80}, {13'h0020, 13'h0020, 13'h1fc0});
        $display("test pixel path done");
    endtask
    task automatic t_up;
        wr(12'h11c, 32'h00000040);
        wr(12'h120, 32'h00000000);
        @(posedge sys_clk);
        cvbs_in <= 13'h0100;
        cvbs_in_valid <= 1;
        @(posedge sys_clk);
        cvbs_in_valid <= 0;
        #1 chk("interp pair", up_out, {13'h0100, 13'h0080});
        @(posedge sys_clk) #1 chk("pairs taken", pair_count, 39'h1);
        $display("test upsampler done");
    endtask
    task automatic t_cap;
        wr(12'h0a0, 32'h00000000);
        wr(12'h124, 32'h0000a503);
        wr(12'h128, 32'h00001234);
        wr(12'h12c, 32'h00005678);
        rd(12'h140);
        chk("fresh flags", rd_val, 32'h3);
        cap(10'h015, 1, 10'h312, 10'h234);
        cap(10'h11c, 0, 10'h356, 10'h278);
        cap(10'h015, 1, 10'h3a5, 10'h2a5);
        wr(12'h0a0, 32'h00000010);
        cap(10'h14f, 0, 10'h3a5, 10'h2a5);
        cap(10'h015, 1, 10'h000, 10'h000);
        wr(12'h0a0, 32'h00000020);
        cap(10'h016, 1, 10'h3a5, 10'h2a5);
        wr(12'h0a0, 32'h00000030);
        cap(10'h016, 1, 10'h000, 10'h000);
        wr(12'h0a0, 32'h00000000);
        for (int s = 0; s < 4; s++) begin
            wr(12'h124, 32'h0000a500 | s);
            cap(10'h015, 1, s[0] ? 10'h3a5 : 10'h000, s[0] ? 10'h2a5 : 10'h000);
            cap(10'h11c, 0, s[1] ? 10'h3a5 : 10'h000, s[1] ? 10'h2a5 : 10'h000);
        end
        @(posedge sys_clk) #1 chk("bytes taken", byte_count, 39'h12);
        $display("test captions done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    // a hang is cut short and counted as a mismatch
    initial begin
        #2000000;
        bad_count++;
        finish_test;
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 0;
        t_regs;
        t_pix;
        t_up;
        t_cap;
        finish_test;
    end
endmodule
